// [rtl/overtemp_pkg.sv]
// package: constants and types of the over-temperature fault response block
// Behaviour
// - response code 00 keeps the output regulating and ignores the fault.
// - code 01 runs on for the programmed delay, then follows the retry field.
// - code 10 disables the output at once, then follows the retry field.
// - code 11 latches off until fault bit or clear-all command clears it.
// - reset, or output commanded off then on, also clears a latched fault.
// - retry field 000 makes no restart and keeps the output off until cleared.
// - retry codes 1..6 restart that many times, then latch off until cleared.
// - starts of restart attempts are spaced by the delay count times unit.
// - retry code 111 restarts forever until commanded off or another fault.
// - bits 2:0 count delay units for run-on or retry spacing; 0 means one.
// - configuration is one byte, written and read back over byte transfers.
// - delay codes 1..7 mean 2, 4, 8 up to 128 units, doubling each step.
// - one delay unit's length comes from the separate time-unit setting.
package overtemp_pkg;
   // command codes seen on the management bus
   localparam logic [7:0] CMD_OT_RESPONSE  = 8'h50;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_STATUS_TEMP  = 8'h7d;
   localparam logic [7:0] TIME_UNIT_CMD    = 8'hd2;  // home of the time-unit setting
   // configuration byte layout
   localparam int RESP_HI  = 7;
   localparam int RESP_LO  = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   localparam int STATUS_OT_BIT = 7;
   localparam logic [7:0] RESPONSE_RESET = 8'h80;  // disable, no retry, one unit
   localparam logic [2:0] RETRY_NONE    = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // timing: time unit is counted in microseconds
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS         = 1000;
   localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
   localparam logic [6:0] US_LAST = 7'(CYC_PER_US - 1);

   typedef enum logic [1:0] {
      RESP_IGNORE   = 2'h0,
      RESP_CONTINUE = 2'h1,
      RESP_DISABLE  = 2'h2,
      RESP_LATCH    = 2'h3
   } resp_mode_t;

   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_LATCH = 4'b1000
   } ot_state_t;

   typedef struct packed {
      logic       write;
      logic [7:0] code;
      logic [7:0] wdata;
   } cmd_req_t;
endpackage

// [rtl/overtemp_fault_response.sv]
// over-temperature fault response: config byte, restart sequencing and status flag
module overtemp_fault_response (
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   input  wire logic                  i_cmd_valid,
   input  wire overtemp_pkg::cmd_req_t i_cmd,
   input  wire logic                  i_ot_fault,
   input  wire logic                  i_on_cmd,
   input  wire logic                  i_other_shutdown,
   input  wire logic [7:0]            i_time_unit_us,
   output logic                       o_rd_valid,
   output logic [7:0]                 o_rd_data,
   output logic                       o_cmd_nack,
   output logic                       o_output_enable,
   output logic                       o_ot_fault_flag,
   output logic                       o_latched_off
);
   import overtemp_pkg::*;

   logic [7:0] resp_r;
   logic       rd_valid_r;
   logic [7:0] rd_data_r;
   logic       nack_r;
   logic       flag_r;
   logic       out_en_r;
   ot_state_t  state_r;
   ot_state_t  state_nxt;
   logic [2:0] att_r;
   logic [2:0] att_nxt;
   logic       tmr_start;
   logic       tmr_busy_r;
   logic [6:0] us_cnt_r;
   logic [7:0] unit_us_cnt_r;
   logic [7:0] units_left_r;
   logic       tmr_done;
   logic       us_last;
   logic       unit_last;
   logic [7:0] unit_us;
   logic       clr_all;
   logic       clr_bit;
   logic       clear_evt;
   logic       wr_resp;
   logic       rd_resp;
   logic       rd_status;
   resp_mode_t mode;
   logic [2:0] retries;
   logic [2:0] delay_code;

   assign mode       = resp_mode_t'(resp_r[RESP_HI:RESP_LO]);
   assign retries    = resp_r[RETRY_HI:RETRY_LO];
   assign delay_code = resp_r[DELAY_HI:DELAY_LO];

   // command decode; only the three codes below are known here
   assign wr_resp   = i_cmd_valid && i_cmd.write && (i_cmd.code == CMD_OT_RESPONSE);
   assign rd_resp   = i_cmd_valid && !i_cmd.write && (i_cmd.code == CMD_OT_RESPONSE);
   assign rd_status = i_cmd_valid && !i_cmd.write && (i_cmd.code == CMD_STATUS_TEMP);
   assign clr_all   = i_cmd_valid && i_cmd.write && (i_cmd.code == CMD_CLEAR_FAULTS);
   assign clr_bit   = i_cmd_valid && i_cmd.write && (i_cmd.code == CMD_STATUS_TEMP)
                      && i_cmd.wdata[STATUS_OT_BIT];
   assign clear_evt = clr_all || clr_bit;

   // configuration byte: plain byte write and byte read back
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         resp_r <= RESPONSE_RESET;
      end else if (wr_resp) begin
         resp_r <= i_cmd.wdata;
      end
   end

   // read answer one cycle after the request; unknown codes are nacked
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rd_valid_r <= 1'b0;
         rd_data_r  <= 8'h00;
         nack_r     <= 1'b0;
      end else begin
         rd_valid_r <= rd_resp || rd_status;
         nack_r     <= i_cmd_valid && !wr_resp && !rd_resp && !rd_status && !clr_all
                       && (i_cmd.code != CMD_STATUS_TEMP || !i_cmd.write);
         if (rd_resp) begin
            rd_data_r <= resp_r;
         end else if (rd_status) begin
            rd_data_r <= {flag_r, 7'h00};
         end
      end
   end

   // status flag; a fault in the clearing cycle wins so no event is lost
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         flag_r <= 1'b0;
      end else if (i_ot_fault) begin
         flag_r <= 1'b1;
      end else if (clear_evt) begin
         flag_r <= 1'b0;
      end
   end

   // delay timer: 2**code units, each unit i_time_unit_us microseconds, a zero setting taken as one
   assign unit_us   = (i_time_unit_us == 8'h00) ? 8'h01 : i_time_unit_us;
   assign us_last   = (us_cnt_r == US_LAST);
   assign unit_last = (unit_us_cnt_r == unit_us - 8'h01);
   assign tmr_done  = tmr_busy_r && us_last && unit_last && (units_left_r == 8'h00);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tmr_busy_r    <= 1'b0;
         us_cnt_r      <= 7'h00;
         unit_us_cnt_r <= 8'h00;
         units_left_r  <= 8'h00;
      end else if (tmr_start) begin
         tmr_busy_r    <= 1'b1;
         us_cnt_r      <= 7'h00;
         unit_us_cnt_r <= 8'h00;
         units_left_r  <= (8'h01 << delay_code) - 8'h01;
      end else if (tmr_busy_r) begin
         if (state_nxt == ST_RUN || state_nxt == ST_LATCH) begin
            tmr_busy_r <= 1'b0;
         end
         us_cnt_r <= us_last ? 7'h00 : us_cnt_r + 7'h01;
         if (us_last) begin
            unit_us_cnt_r <= unit_last ? 8'h00 : unit_us_cnt_r + 8'h01;
            if (unit_last) begin
               if (units_left_r == 8'h00) begin
                  tmr_busy_r <= 1'b0;
               end else begin
                  units_left_r <= units_left_r - 8'h01;
               end
            end
         end
      end
   end

   // next state of the response sequencer
   always_comb begin
      state_nxt = state_r;
      att_nxt   = att_r;
      tmr_start = 1'b0;
      if (!i_on_cmd) begin
         state_nxt = ST_RUN;
         att_nxt   = 3'h0;
      end else if (i_other_shutdown) begin
         state_nxt = ST_LATCH;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (!i_ot_fault) begin
                  att_nxt = 3'h0;
               end else if (mode == RESP_IGNORE) begin
                  state_nxt = ST_RUN;
               end else if (mode == RESP_LATCH) begin
                  state_nxt = ST_LATCH;
               end else if (mode == RESP_CONTINUE && att_r == 3'h0) begin
                  state_nxt = ST_DELAY;
                  tmr_start = 1'b1;
               end else if (retries == RETRY_NONE) begin
                  state_nxt = ST_LATCH;
               end else if (retries == RETRY_FOREVER || att_r < retries) begin
                  state_nxt = ST_WAIT;
                  tmr_start = 1'b1;
               end else begin
                  state_nxt = ST_LATCH;
               end
            end
            ST_DELAY: begin
               if (tmr_done && !i_ot_fault) begin
                  state_nxt = ST_RUN;
               end else if (tmr_done && retries == RETRY_NONE) begin
                  state_nxt = ST_LATCH;
               end else if (tmr_done) begin
                  state_nxt = ST_WAIT;
                  tmr_start = 1'b1;
               end
            end
            ST_WAIT: begin
               if (clear_evt) begin
                  state_nxt = ST_RUN;
                  att_nxt   = 3'h0;
               end else if (tmr_done) begin
                  state_nxt = ST_RUN;
                  att_nxt   = (att_r == 3'h7) ? att_r : att_r + 3'h1;
               end
            end
            ST_LATCH: begin
               if (clear_evt) begin
                  state_nxt = ST_RUN;
                  att_nxt   = 3'h0;
               end
            end
            default: begin
               state_nxt = ST_LATCH;
               att_nxt   = 3'h0;
            end
         endcase
      end
   end

   // sequencer state and output enable; the enable is registered for a clean pin
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_r  <= ST_RUN;
         att_r    <= 3'h0;
         out_en_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         att_r    <= att_nxt;
         out_en_r <= i_on_cmd && !i_other_shutdown
                     && (state_nxt == ST_RUN || state_nxt == ST_DELAY);
      end
   end

   assign o_rd_valid      = rd_valid_r;
   assign o_rd_data       = rd_data_r;
   assign o_cmd_nack      = nack_r;
   assign o_output_enable = out_en_r;
   assign o_ot_fault_flag = flag_r;
   assign o_latched_off   = (state_r == ST_LATCH);

   sequence s_fault_in_run;
      i_on_cmd && !i_other_shutdown && state_r == ST_RUN && i_ot_fault;
   endsequence

   property p_ignore;
      @(posedge i_clk) disable iff (i_reset)
      s_fault_in_run ##0 (mode == RESP_IGNORE) |=> o_output_enable [*2] or (!i_on_cmd || i_other_shutdown);
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored fault dropped output");

   property p_delay_runs;
      @(posedge i_clk) disable iff (i_reset)
      state_r == ST_DELAY && !tmr_done && i_on_cmd && !i_other_shutdown |=> o_output_enable;
   endproperty
   a_delay_runs: assert property (p_delay_runs) else $error("output off during run-on delay");

   property p_disable;
      @(posedge i_clk) disable iff (i_reset)
      s_fault_in_run ##0 (mode == RESP_DISABLE) |=> !o_output_enable && state_r != ST_RUN;
   endproperty
   a_disable: assert property (p_disable) else $error("disable response kept output on");

   property p_latch_holds;
      @(posedge i_clk) disable iff (i_reset)
      state_r == ST_LATCH && i_on_cmd && !clear_evt |=> state_r == ST_LATCH && !o_output_enable;
   endproperty
   a_latch_holds: assert property (p_latch_holds) else $error("latched off left without clear");

   property p_off_clears;
      @(posedge i_clk) disable iff (i_reset)
      !i_on_cmd |=> state_r == ST_RUN && att_r == 3'h0 && !o_output_enable;
   endproperty
   a_off_clears: assert property (p_off_clears) else $error("off command did not clear state");

   property p_no_retry;
      @(posedge i_clk) disable iff (i_reset)
      s_fault_in_run ##0 (mode == RESP_DISABLE && retries == RETRY_NONE) |=> state_r == ST_LATCH;
   endproperty
   a_no_retry: assert property (p_no_retry) else $error("retry 000 did not latch");

   property p_retry_limit;
      @(posedge i_clk) disable iff (i_reset)
      s_fault_in_run ##0 (mode == RESP_DISABLE && retries != RETRY_FOREVER && retries != RETRY_NONE
      && att_r >= retries) |=> state_r == ST_LATCH;
   endproperty
   a_retry_limit: assert property (p_retry_limit) else $error("restart beyond retry count");

   property p_forever;
      @(posedge i_clk) disable iff (i_reset)
      s_fault_in_run ##0 (mode == RESP_DISABLE && retries == RETRY_FOREVER) |=> state_r == ST_WAIT;
   endproperty
   a_forever: assert property (p_forever) else $error("continuous retry stopped");

   property p_units;
      @(posedge i_clk) disable iff (i_reset)
      tmr_start |=> units_left_r == (8'h01 << $past(delay_code)) - 8'h01;
   endproperty
   a_units: assert property (p_units) else $error("delay unit count wrong");

   property p_readback;
      @(posedge i_clk) disable iff (i_reset)
      rd_resp |=> o_rd_valid && o_rd_data == $past(resp_r);
   endproperty
   a_readback: assert property (p_readback) else $error("config read returned wrong byte");

   property p_flag;
      @(posedge i_clk) disable iff (i_reset)
      i_ot_fault |=> o_ot_fault_flag;
   endproperty
   a_flag: assert property (p_flag) else $error("fault flag not latched");

   // a clear in the latched state must restart from a clean attempt count
   property p_clear_latch;
      @(posedge i_clk) disable iff (i_reset)
      state_r == ST_LATCH && clear_evt && i_on_cmd && !i_other_shutdown |=> state_r == ST_RUN && att_r == 3'h0;
   endproperty
   a_clear_latch: assert property (p_clear_latch) else $error("clear did not release latch");

   // a retry wait with no running timer would never end
   property p_wait_timed;
      @(posedge i_clk) disable iff (i_reset)
      state_r == ST_WAIT |-> tmr_busy_r;
   endproperty
   a_wait_timed: assert property (p_wait_timed) else $error("retry wait without running timer");

   property p_refuse;
      @(posedge i_clk) disable iff (i_reset)
      i_cmd_valid && !i_cmd.write && i_cmd.code == CMD_CLEAR_FAULTS |=> o_cmd_nack && !o_rd_valid;
   endproperty
   a_refuse: assert property (p_refuse) else $error("read of clear command not refused");
endmodule

// [testbench/host_model.sv]
// host model: issues single-byte management commands and collects the answers
module host_model (
   input  wire logic                  i_clk,
   input  wire logic                  i_rd_valid,
   input  wire logic [7:0]            i_rd_data,
   input  wire logic                  i_cmd_nack,
   output logic                       o_cmd_valid,
   output overtemp_pkg::cmd_req_t     o_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   import overtemp_pkg::*;

   // idle bus at time zero
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd       = '0;
   end

   // one byte per transfer, strobe for one cycle; released fields flip so stale data never looks valid
   task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                       output logic [7:0] rd, output logic nk);
      rd = 'x;
      nk = 1'b0;
      @(negedge i_clk);
      o_cmd_valid = 1'b1;
      o_cmd       = '{write: w, code: c, wdata: d};
      @(negedge i_clk);
      o_cmd_valid = 1'b0;
      o_cmd       = '{write: ~w, code: ~c, wdata: ~d};
      // answer stands one cycle, so look at each of the next two cycles
      repeat (2) begin
         if (i_rd_valid === 1'b1) rd = i_rd_data;
         if (i_cmd_nack === 1'b1) nk = 1'b1;
         @(negedge i_clk);
      end
   endtask
endmodule

// [testbench/testbench.sv]
// testbench: over-temperature fault response sequencing and config byte
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import overtemp_pkg::*;
   logic clk, rst, cv, flt, on, oth, rv, nk, oe, flag, lat, nkv;
   cmd_req_t cmd;
   logic [7:0] unit, rd, rdv;
   int bad_count = 0;
   int checked = 0;
   int n;

   overtemp_fault_response DUT (.i_clk(clk), .i_reset(rst), .i_cmd_valid(cv), .i_cmd(cmd),
      .i_ot_fault(flt), .i_on_cmd(on), .i_other_shutdown(oth), .i_time_unit_us(unit),
      .o_rd_valid(rv), .o_rd_data(rd), .o_cmd_nack(nk), .o_output_enable(oe),
      .o_ot_fault_flag(flag), .o_latched_off(lat));
   host_model host (.i_clk(clk), .i_rd_valid(rv), .i_rd_data(rd), .i_cmd_nack(nk),
      .o_cmd_valid(cv), .o_cmd(cmd));

   // free-running 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic err(string m);
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
      checked++;
      if (got !== exp) err(m);
   endtask
   task automatic rng(int v, int lo, int hi, string m);
      checked++;
      if (v < lo || v > hi) err(m);
   endtask
   // counts cycles until the output enable reaches lv; bounded so a hang ends the run
   task automatic wait_oe(logic lv);
      n = 0;
      while (oe !== lv) begin
         @(negedge clk);
         n++;
         if (n > 2000) begin
            err("output enable wait timed out");
            close_out();
         end
      end
   endtask
   task automatic op(logic w, logic [7:0] c, logic [7:0] d);
      host.xfer(w, c, d, rdv, nkv);
   endtask
   task automatic clear_all();
      flt = 1'b0;
      op(1'b1, CMD_CLEAR_FAULTS, 8'h00);
      wait_oe(1'b1);
   endtask

   task automatic s_regs();
      op(1'b0, CMD_OT_RESPONSE, 8'h00);
      chk(rdv, RESPONSE_RESET, "config reset value");
      chk(oe, 1'b1, "enable after reset");
      op(1'b1, CMD_OT_RESPONSE, 8'h5a);
      op(1'b0, CMD_OT_RESPONSE, 8'h00);
      chk(rdv, 8'h5a, "config readback");
      op(1'b0, 8'h51, 8'h00);
      chk(nkv, 1'b1, "unknown code nack");
      op(1'b0, CMD_CLEAR_FAULTS, 8'h00);
      chk(nkv, 1'b1, "read of clear nack");
   endtask
   task automatic s_ignore();
      op(1'b1, CMD_OT_RESPONSE, 8'h00);
      flt = 1'b1;
      n = 0;
      repeat (400) begin
         @(negedge clk);
         if (oe !== 1'b1) n++;
      end
      rng(n, 0, 0, "ignore mode dropped output");
      chk(flag, 1'b1, "fault flag latched");
      op(1'b0, CMD_STATUS_TEMP, 8'h00);
      chk(rdv, 8'h80, "status byte");
      clear_all();
      chk(flag, 1'b0, "flag cleared");
   endtask
   task automatic s_disable();
      op(1'b1, CMD_OT_RESPONSE, 8'h88);  // disable, one retry, one unit
      flt = 1'b1;
      @(negedge clk);
      chk(oe, 1'b0, "immediate disable");
      wait_oe(1'b1);
      rng(n, 124, 129, "retry spacing one unit");
      wait_oe(1'b0);
      rng(n, 0, 3, "failed retry shuts off");
      repeat (300) @(negedge clk);
      chk({oe, lat}, 2'b01, "stays off after last retry");
      clear_all();
      rng(n, 0, 4, "clear restarts output");
   endtask
   task automatic s_latch();
      op(1'b1, CMD_OT_RESPONSE, 8'hc0);
      flt = 1'b1;
      repeat (2) @(negedge clk);
      flt = 1'b0;
      repeat (300) @(negedge clk);
      chk({oe, lat}, 2'b01, "latched off after fault gone");
      op(1'b1, CMD_STATUS_TEMP, 8'h80);
      wait_oe(1'b1);
      rng(n, 0, 4, "status bit clear releases latch");
      flt = 1'b1;
      repeat (2) @(negedge clk);
      flt = 1'b0;
      on = 1'b0;
      repeat (3) @(negedge clk);
      chk(oe, 1'b0, "commanded off");
      on = 1'b1;
      wait_oe(1'b1);
      rng(n, 0, 4, "off then on clears latch");
   endtask
   task automatic s_cont();
      op(1'b1, CMD_OT_RESPONSE, 8'h41);  // run on, no retry, code 1
      flt = 1'b1;
      wait_oe(1'b0);
      rng(n, 248, 253, "run-on lasts two units");
      repeat (300) @(negedge clk);
      chk({oe, lat}, 2'b01, "no retry keeps output off");
      clear_all();
   endtask
   // unit of two microseconds: run-on, then one retry, then latch
   task automatic s_unit();
      unit = 8'h02;
      op(1'b1, CMD_OT_RESPONSE, 8'h48);  // run on, one retry, code 0
      flt = 1'b1;
      wait_oe(1'b0);
      rng(n, 249, 253, "run-on lasts one longer unit");
      wait_oe(1'b1);
      rng(n, 248, 252, "retry spacing follows unit length");
      wait_oe(1'b0);
      rng(n, 0, 3, "failed retry after run-on shuts off");
      chk(lat, 1'b1, "latched after last retry");
      clear_all();
      unit = 8'h01;
   endtask
   task automatic s_forever();
      op(1'b1, CMD_OT_RESPONSE, 8'hba);  // disable, endless retries, code 2
      flt = 1'b1;
      wait_oe(1'b0);
      rng(n, 1, 1, "endless mode disables at once");
      repeat (4) begin
         wait_oe(1'b1);
         rng(n, 496, 505, "endless retry spacing four units");
         wait_oe(1'b0);
      end
      chk(lat, 1'b0, "endless retry never latches");
      on = 1'b0;
      flt = 1'b0;
      repeat (700) @(negedge clk);
      chk(oe, 1'b0, "off command stops retrying");
      on = 1'b1;
      wait_oe(1'b1);
   endtask
   task automatic s_other();
      oth = 1'b1;
      repeat (2) @(negedge clk);
      oth = 1'b0;
      repeat (3) @(negedge clk);
      chk({oe, lat}, 2'b01, "other fault shuts down");
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      wait_oe(1'b1);
      rng(n, 0, 3, "reset clears latch");
      op(1'b0, CMD_OT_RESPONSE, 8'h00);
      chk(rdv, RESPONSE_RESET, "config back to reset value");
      flt = 1'b1;
      repeat (2) @(negedge clk);
      chk({oe, lat}, 2'b01, "reset config disables without retry");
      clear_all();
   endtask

   // main sequence; inputs move only at the falling edge
   initial begin
      rst = 1'b1;
      flt = 1'b0;
      on = 1'b1;
      oth = 1'b0;
      unit = 8'h01;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      s_regs();
      s_ignore();
      s_disable();
      s_latch();
      s_cont();
      s_unit();
      s_forever();
      s_other();
      close_out();
   end
endmodule
